// ==== rtl/paev_defines.vh ====
// constants for the process alarm evaluator: register map, fields, reset values, timing
`ifndef PAEV_DEFINES_VH
`define PAEV_DEFINES_VH

// ----------------------------------------
// register byte offsets (one word per register)
// ----------------------------------------
`define PAEV_OFF_SETPOINT 12'h000
`define PAEV_OFF_PV 12'h004
`define PAEV_OFF_CTRL 12'h008
`define PAEV_OFF_STATUS 12'h00C
`define PAEV_OFF_MASK 12'h010
`define PAEV_OFF_OUTSEL 12'h014
`define PAEV_OFF_ALSTATE 12'h018
`define PAEV_OFF_CH_BASE 12'h040
`define PAEV_CH_STRIDE 12'h020
`define PAEV_CH_TYPE 12'h000
`define PAEV_CH_VALUE 12'h004
`define PAEV_CH_UPPER 12'h008
`define PAEV_CH_LOWER 12'h00C
`define PAEV_CH_ONDLY 12'h010
`define PAEV_CH_OFFDLY 12'h014

// ----------------------------------------
// sizes and fields
// ----------------------------------------
`define PAEV_NCH 3
`define PAEV_NAUX 3
`define PAEV_VW 16
`define PAEV_DLY_MAX 10'h3E7
`define PAEV_CTRL_RESTART 0
`define PAEV_CTRL_HEATER_VARIANT 1
`define PAEV_OUTSEL_RESET 6'h24

// ----------------------------------------
// alarm type codes
// ----------------------------------------
`define PAEV_T_OFF 5'h00
`define PAEV_T_BAND_OUT 5'h01
`define PAEV_T_UPPER 5'h02
`define PAEV_T_LOWER 5'h03
`define PAEV_T_BAND_IN 5'h04
`define PAEV_T_BAND_OUT_SB 5'h05
`define PAEV_T_UPPER_SB 5'h06
`define PAEV_T_LOWER_SB 5'h07
`define PAEV_T_ABS_HI 5'h08
`define PAEV_T_ABS_LO 5'h09
`define PAEV_T_ABS_HI_SB 5'h0A
`define PAEV_T_ABS_LO_SB 5'h0B
`define PAEV_T_LOOP_BREAK 5'h0C
`define PAEV_T_RATE 5'h0D
`define PAEV_T_LAST 5'h12
`define PAEV_T_RESET 5'h02

// ----------------------------------------
// timing: one second tick at 125 MHz
// ----------------------------------------
`define PAEV_TICK_NS 1000000000
`define PAEV_CLK_NS 8
`define PAEV_TICK_CYCLES (`PAEV_TICK_NS / `PAEV_CLK_NS)

`endif

// ==== rtl/paev_compare.v ====
// raw alarm condition and standby sequence for one alarm channel
`timescale 1ns/100ps
`include "paev_defines.vh"

module paev_compare (
  input wire ref_clk_i,
  input wire reset_i,
  input wire restart_i,
  input wire [4:0] alarm_type_i,
  input wire signed [15:0] process_value_i,
  input wire signed [15:0] set_point_i,
  input wire signed [15:0] alarm_value_i,
  input wire signed [15:0] upper_dev_i,
  input wire signed [15:0] lower_dev_i,
  input wire ext_alarm_i,
  output wire raw_alarm_o
);

  // ----------------------------------------
  // comparisons, widened so sums never overflow
  // ----------------------------------------
  wire signed [17:0] pv = {{2{process_value_i[15]}}, process_value_i};
  wire signed [17:0] sp = {{2{set_point_i[15]}}, set_point_i};
  wire signed [17:0] xv = {{2{alarm_value_i[15]}}, alarm_value_i};
  wire signed [17:0] hi_lim = sp + {{2{upper_dev_i[15]}}, upper_dev_i};
  wire signed [17:0] lo_lim = sp - {{2{lower_dev_i[15]}}, lower_dev_i};
  wire band_out = (pv > hi_lim) || (pv < lo_lim);
  wire band_in = (pv >= lo_lim) && (pv <= hi_lim);
  wire dev_hi = (pv - sp) >= xv;
  wire dev_lo = (sp - pv) >= xv;
  reg cond;
  reg standby_type;
  reg standby_q;

  always @* begin
    cond = 1'b0;
    standby_type = 1'b0;
    case (alarm_type_i)
      `PAEV_T_BAND_OUT: cond = band_out; // [RULE5]
      `PAEV_T_UPPER: cond = dev_hi; // [RULE7]
      `PAEV_T_LOWER: cond = dev_lo; // [RULE8]
      `PAEV_T_BAND_IN: cond = band_in; // [RULE6]
      `PAEV_T_BAND_OUT_SB: begin
        cond = band_out; // [RULE9]
        standby_type = 1'b1;
      end
      `PAEV_T_UPPER_SB: begin
        cond = dev_hi; // [RULE10]
        standby_type = 1'b1;
      end
      `PAEV_T_LOWER_SB: begin
        cond = dev_lo; // [RULE10]
        standby_type = 1'b1;
      end
      `PAEV_T_ABS_HI: cond = pv > xv; // [RULE11]
      `PAEV_T_ABS_LO: cond = pv < xv; // [RULE12]
      `PAEV_T_ABS_HI_SB: begin
        cond = pv > xv; // [RULE13]
        standby_type = 1'b1;
      end
      `PAEV_T_ABS_LO_SB: begin
        cond = pv < xv; // [RULE13]
        standby_type = 1'b1;
      end
      // loop break and change rate are judged outside, brought in as a level
      `PAEV_T_LOOP_BREAK: cond = ext_alarm_i; // [RULE14]
      `PAEV_T_RATE: cond = ext_alarm_i; // [RULE15]
      default: cond = 1'b0; // [RULE1]
    endcase
  end

  // ----------------------------------------
  // standby: armed at reset or restart, released once pv is seen safe
  // ----------------------------------------
  always @(posedge ref_clk_i) begin
    if (reset_i || restart_i) begin
      standby_q <= 1'b1; // [RULE17]
    end else if (!cond) begin
      standby_q <= 1'b0; // [RULE17]
    end
  end

  assign raw_alarm_o = cond && !(standby_type && standby_q);

endmodule // paev_compare

// ==== rtl/paev_delay.v ====
// on and off delay filter in whole seconds for one alarm output
`timescale 1ns/100ps
`include "paev_defines.vh"

module paev_delay (
  input wire ref_clk_i,
  input wire reset_i,
  input wire tick_i,
  input wire raw_i,
  input wire [9:0] on_delay_i,
  input wire [9:0] off_delay_i,
  output wire alarm_o
);

  reg out_q;
  reg [9:0] cnt_q;

  // ----------------------------------------
  // counter restarts whenever raw agrees with the output
  // ----------------------------------------
  wire [9:0] limit = out_q ? off_delay_i : on_delay_i;

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      out_q <= 1'b0;
      cnt_q <= 10'h000;
    end else if (raw_i == out_q) begin
      cnt_q <= 10'h000; // [RULE18]
    end else if (cnt_q >= limit) begin
      out_q <= raw_i; // [RULE2] [RULE18]
      cnt_q <= 10'h000;
    end else if (tick_i) begin
      cnt_q <= cnt_q + 10'h001;
    end
  end

  assign alarm_o = out_q;

endmodule // paev_delay

// ==== rtl/paev_top.v ====
// process alarm evaluator: apb registers, alarm channels, delays, output routing
//
// Contract
// RULE1: nineteen types per channel, default two, zero off
// RULE2: on and off delays, 0 to 999 s
// RULE3: output assignment selects alarm per aux output
// RULE4: heater variant: alarm 1 heater unless assigned
// RULE5: type 1 alarms outside deviation band
// RULE6: type 4 alarms inside deviation band
// RULE7: type 2 alarms pv above sp by x
// RULE8: type 3 alarms pv below sp by x
// RULE9: type 5 is type 1 with standby
// RULE10: types 6, 7 deviation alarms with standby
// RULE11: type 8 alarms pv above x
// RULE12: type 9 alarms pv below x
// RULE13: types 10, 11 absolute alarms with standby
// RULE14: type 12 loop break, channel 1 only
// RULE15: type 13 selects change rate alarm
// RULE16: separate upper and lower deviation per alarm
// RULE17: standby suppresses until pv first seen safe
// RULE18: output follows raw only after held for delay
`timescale 1ns/100ps
`include "paev_defines.vh"

module paev_top (
  input wire ref_clk_i,
  input wire reset_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire pready_o,
  output reg [31:0] prdata_o,
  output wire pslverr_o,
  input wire [15:0] process_value_i,
  input wire process_value_valid_i,
  input wire heater_alarm_i,
  input wire loop_break_alarm_i,
  input wire [2:0] rate_alarm_i,
  output reg [2:0] aux_out_o,
  output wire irq_o
);

  localparam NCH = `PAEV_NCH;
  // the divide is done at 32 bits, then cut to the counter width
  localparam [31:0] TICK_LAST_W = `PAEV_TICK_CYCLES - 1;
  localparam [26:0] TICK_LAST = TICK_LAST_W[26:0];

  // ----------------------------------------
  // address decode helpers
  // ----------------------------------------
  function ch_hit;
    input [11:0] addr;
    input [11:0] field;
    input integer ch;
    begin
      ch_hit = (addr == (`PAEV_OFF_CH_BASE + `PAEV_CH_STRIDE * ch[11:0] + field));
    end
  endfunction

  // legal type for a channel: loop break only on channel 0
  function type_ok;
    input [4:0] t;
    input integer ch;
    begin
      type_ok = (t <= `PAEV_T_LAST) && !(t == `PAEV_T_LOOP_BREAK && ch != 0); // [RULE1] [RULE14]
    end
  endfunction

  // delays beyond 999 s clamp to 999 rather than wrapping to a short delay
  function [9:0] dly_clamp;
    input [31:0] v;
    begin
      dly_clamp = (v > {22'h000000, `PAEV_DLY_MAX}) ? `PAEV_DLY_MAX : v[9:0]; // [RULE2]
    end
  endfunction

  // strobe qualified by one shared register address
  function reg_hit;
    input strobe;
    input [11:0] addr;
    input [11:0] target;
    begin
      reg_hit = strobe && (addr == target);
    end
  endfunction

  // ----------------------------------------
  // shared registers
  // ----------------------------------------
  reg [15:0] set_point_q;
  reg [15:0] pv_q;
  reg [1:0] ctrl_q;
  reg [2:0] status_q;
  reg [2:0] mask_q;
  reg [5:0] outsel_q;
  reg [26:0] tick_cnt_q;
  reg tick_q;
  reg [2:0] alarm_prev_q;

  wire wr = psel_i && penable_i && pwrite_i;
  wire rd = psel_i && penable_i && !pwrite_i;
  wire [2:0] alarm_w;
  wire [2:0] raw_w;
  reg [31:0] rdata_d;
  reg hit_d;

  // every register answers at once, so no transfer ever waits
  assign pready_o = 1'b1;

  // ----------------------------------------
  // per channel registers and datapath
  // ----------------------------------------
  reg [4:0] type_q [0:NCH-1];
  reg [15:0] value_q [0:NCH-1];
  reg [15:0] upper_q [0:NCH-1];
  reg [15:0] lower_q [0:NCH-1];
  reg [9:0] ondly_q [0:NCH-1];
  reg [9:0] offdly_q [0:NCH-1];

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      always @(posedge ref_clk_i) begin
        if (reset_i) begin
          type_q[g] <= `PAEV_T_RESET; // [RULE1]
          value_q[g] <= 16'h0000;
          upper_q[g] <= 16'h0000;
          lower_q[g] <= 16'h0000;
          ondly_q[g] <= 10'h000;
          offdly_q[g] <= 10'h000;
        end else if (wr) begin
          // an illegal type write is dropped, the old type stays
          if (ch_hit(paddr_i, `PAEV_CH_TYPE, g) && type_ok(pwdata_i[4:0], g) && pwdata_i[31:5] == 27'h0) begin
            type_q[g] <= pwdata_i[4:0]; // [RULE1] [RULE14]
          end
          if (ch_hit(paddr_i, `PAEV_CH_VALUE, g)) begin
            value_q[g] <= pwdata_i[15:0];
          end
          if (ch_hit(paddr_i, `PAEV_CH_UPPER, g)) begin
            upper_q[g] <= pwdata_i[15:0]; // [RULE16]
          end
          if (ch_hit(paddr_i, `PAEV_CH_LOWER, g)) begin
            lower_q[g] <= pwdata_i[15:0]; // [RULE16]
          end
          if (ch_hit(paddr_i, `PAEV_CH_ONDLY, g)) begin
            ondly_q[g] <= dly_clamp(pwdata_i); // [RULE2]
          end
          if (ch_hit(paddr_i, `PAEV_CH_OFFDLY, g)) begin
            offdly_q[g] <= dly_clamp(pwdata_i); // [RULE2]
          end
        end
      end

      // loop break reaches channel 0 only; each channel has its own rate level
      paev_compare u_cmp (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .restart_i(ctrl_q[`PAEV_CTRL_RESTART]),
        .alarm_type_i(type_q[g]),
        .process_value_i(pv_q),
        .set_point_i(set_point_q),
        .alarm_value_i(value_q[g]),
        .upper_dev_i(upper_q[g]),
        .lower_dev_i(lower_q[g]),
        .ext_alarm_i(g == 0 && type_q[g] == `PAEV_T_LOOP_BREAK ? loop_break_alarm_i : rate_alarm_i[g]),
        .raw_alarm_o(raw_w[g])
      );

      paev_delay u_dly (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .tick_i(tick_q),
        .raw_i(raw_w[g]),
        .on_delay_i(ondly_q[g]),
        .off_delay_i(offdly_q[g]),
        .alarm_o(alarm_w[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // shared register writes and events
  // ----------------------------------------
  // events are rising edges of the delayed alarms, not of the raw conditions
  wire [2:0] rise = alarm_w & ~alarm_prev_q;
  wire status_rd = reg_hit(rd, paddr_i, `PAEV_OFF_STATUS);

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      set_point_q <= 16'h0000;
      pv_q <= 16'h0000;
      ctrl_q <= 2'h0;
      mask_q <= 3'h0;
      outsel_q <= `PAEV_OUTSEL_RESET;
      status_q <= 3'h0;
      alarm_prev_q <= 3'h0;
    end else begin
      if (reg_hit(wr, paddr_i, `PAEV_OFF_SETPOINT)) begin
        set_point_q <= pwdata_i[15:0];
      end
      if (process_value_valid_i) begin
        pv_q <= process_value_i;
      end
      // restart bit self-clears after one cycle
      if (reg_hit(wr, paddr_i, `PAEV_OFF_CTRL)) begin
        ctrl_q <= pwdata_i[1:0];
      end else begin
        ctrl_q[`PAEV_CTRL_RESTART] <= 1'b0;
      end
      if (reg_hit(wr, paddr_i, `PAEV_OFF_MASK)) begin
        mask_q <= pwdata_i[2:0];
      end
      if (reg_hit(wr, paddr_i, `PAEV_OFF_OUTSEL)) begin
        outsel_q <= pwdata_i[5:0]; // [RULE3]
      end
      // only the bits latched for the reader are cleared, so a rise after the
      // setup phase, or in the read cycle itself, is not lost
      status_q <= (status_q & ~(status_rd ? prdata_o[2:0] : 3'h0)) | rise;
      alarm_prev_q <= alarm_w;
    end
  end

  // ----------------------------------------
  // one second tick for the delay counters
  // ----------------------------------------
  // free running, so the first second of a delay may be short by up to one tick
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      tick_cnt_q <= 27'h0000000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= 27'h0000000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 27'h0000001;
      tick_q <= 1'b0;
    end
  end

  assign irq_o = |(status_q & mask_q);

  // ----------------------------------------
  // output routing: 2 bits per aux output, 0 off, 1..3 alarm channel
  // ----------------------------------------
  function route_sel;
    input [1:0] sel;
    input [2:0] al;
    begin
      case (sel)
        2'h0: route_sel = 1'b0;
        2'h1: route_sel = al[0];
        2'h2: route_sel = al[1];
        2'h3: route_sel = al[2];
        default: route_sel = 1'b0;
      endcase
    end
  endfunction

  // on heater variants, aux output 0 carries the heater alarm until it is assigned to alarm 1
  wire hv = ctrl_q[`PAEV_CTRL_HEATER_VARIANT];
  wire [2:0] aux_d;

  genvar a;
  generate
    for (a = 0; a < `PAEV_NAUX; a = a + 1) begin : g_aux
      wire heat = (a == 0) && hv && (outsel_q[1:0] != 2'h1) && heater_alarm_i; // [RULE4]
      assign aux_d[a] = route_sel(outsel_q[2*a+1:2*a], alarm_w) | heat; // [RULE3]
    end
  endgenerate

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      aux_out_o <= 3'h0;
    end else begin
      aux_out_o <= aux_d; // [RULE3] [RULE4]
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // the mux is combinational; the flop below holds its word for the access phase
  integer i;
  always @* begin
    rdata_d = 32'h00000000;
    hit_d = 1'b1;
    case (paddr_i)
      `PAEV_OFF_SETPOINT: rdata_d = {16'h0000, set_point_q};
      `PAEV_OFF_PV: rdata_d = {16'h0000, pv_q};
      `PAEV_OFF_CTRL: rdata_d = {30'h00000000, ctrl_q};
      `PAEV_OFF_STATUS: rdata_d = {29'h00000000, status_q};
      `PAEV_OFF_MASK: rdata_d = {29'h00000000, mask_q};
      `PAEV_OFF_OUTSEL: rdata_d = {26'h0000000, outsel_q};
      `PAEV_OFF_ALSTATE: rdata_d = {26'h0000000, raw_w, alarm_w};
      default: begin
        // channel windows: an address in none of them reads zero
        hit_d = 1'b0;
        for (i = 0; i < NCH; i = i + 1) begin
          if (ch_hit(paddr_i, `PAEV_CH_TYPE, i)) begin
            rdata_d = {27'h0000000, type_q[i]};
            hit_d = 1'b1;
          end
          if (ch_hit(paddr_i, `PAEV_CH_VALUE, i)) begin
            rdata_d = {16'h0000, value_q[i]};
            hit_d = 1'b1;
          end
          if (ch_hit(paddr_i, `PAEV_CH_UPPER, i)) begin
            rdata_d = {16'h0000, upper_q[i]};
            hit_d = 1'b1;
          end
          if (ch_hit(paddr_i, `PAEV_CH_LOWER, i)) begin
            rdata_d = {16'h0000, lower_q[i]};
            hit_d = 1'b1;
          end
          if (ch_hit(paddr_i, `PAEV_CH_ONDLY, i)) begin
            rdata_d = {22'h000000, ondly_q[i]};
            hit_d = 1'b1;
          end
          if (ch_hit(paddr_i, `PAEV_CH_OFFDLY, i)) begin
            rdata_d = {22'h000000, offdly_q[i]};
            hit_d = 1'b1;
          end
        end
      end
    endcase
  end

  // ----------------------------------------
  // read data flop
  // ----------------------------------------
  // the word is latched at the end of the setup phase, so prdata comes from a
  // flop and the access phase still needs no wait state
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      prdata_o <= 32'h00000000;
    end else if (psel_i && !penable_i) begin
      prdata_o <= rdata_d;
    end
  end

  // unmapped addresses answer with an error; a refused type code does not
  assign pslverr_o = psel_i && penable_i && !hit_d;

endmodule // paev_top

// ==== bench/paev_checker.sv ====
// concurrent checks on the ports of the process alarm evaluator
`timescale 1ns/100ps
module paev_checker (
  input wire ref_clk_i,
  input wire reset_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire pready_o,
  input wire [31:0] prdata_o,
  input wire pslverr_o,
  input wire [2:0] aux_out_o,
  input wire irq_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  wire acc = psel_i & penable_i & pready_o;
  wire hole = (paddr_i >= 12'h01C) && (paddr_i < 12'h040);
  wire [11:0] rel = paddr_i - 12'h040;
  wire tyreg = (paddr_i >= 12'h040) && (rel[11:5] < 7'h03) && (rel[4:0] == 5'h00);
  wire [1:0] ch = rel[6:5];
  reg [4:0] ty_q [0:2];
  reg [5:0] os_q;
  // shadow of accepted type codes; refused codes must leave it alone
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      ty_q[0] <= 5'h02;
      ty_q[1] <= 5'h02;
      ty_q[2] <= 5'h02;
      os_q <= 6'h24;
    end else if (acc && pwrite_i) begin
      if (tyreg && pwdata_i <= 32'h12 && !(pwdata_i == 32'h0C && ch != 2'h0))
        ty_q[ch] <= pwdata_i[4:0];
      if (paddr_i == 12'h014)
        os_q <= pwdata_i[5:0];
    end
  end
  sequence s_type_rd;
    acc && !pwrite_i && tyreg;
  endsequence
  sequence s_aux1_off;
    (os_q[3:2] == 2'h0) [*3];
  endsequence
  sequence s_aux2_off;
    (os_q[5:4] == 2'h0) [*3];
  endsequence
  AST_READY: assert property (psel_i |-> pready_o)
    else $error("pready low during a transfer");
  AST_HOLE_ERR: assert property (acc && hole |-> pslverr_o)
    else $error("no error on unmapped address");
  AST_HOLE_ZERO: assert property (acc && hole && !pwrite_i |-> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_MAP_OK: assert property (acc && paddr_i <= 12'h018 && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
    else $error("error on mapped address");
  AST_TYPE_RB: assert property (s_type_rd |-> prdata_o == {27'h0, ty_q[ch]})
    else $error("alarm type readback wrong");
  AST_AUX1_OFF: assert property (s_aux1_off |-> !aux_out_o[1])
    else $error("unassigned aux1 active");
  AST_AUX2_OFF: assert property (s_aux2_off |-> !aux_out_o[2])
    else $error("unassigned aux2 active");
  AST_RESET_OUT: assert property (disable iff (1'b0) reset_i |=> aux_out_o == 3'h0 && !irq_o)
    else $error("outputs active after reset");
endmodule // paev_checker

bind paev_top paev_checker chk_u (.ref_clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .pready_o, .prdata_o, .pslverr_o, .aux_out_o, .irq_o);

// ==== bench/paev_plant.sv ====
// measurement source feeding process values to the evaluator
`timescale 1ns/100ps
module paev_plant (
  input wire ref_clk_i,
  output reg [15:0] process_value_o,
  output reg process_value_valid_o
);
  initial begin
    process_value_o = 16'h0000;
    process_value_valid_o = 1'b0;
  end
  // off the strobe the bus shows the inverse so a late sample is caught
  task put_pv(input [15:0] v);
    begin
      @(posedge ref_clk_i);
      process_value_o <= v;
      process_value_valid_o <= 1'b1;
      @(posedge ref_clk_i);
      process_value_o <= ~v;
      process_value_valid_o <= 1'b0;
    end
  endtask
endmodule // paev_plant

// ==== bench/paev_top_bench.sv ====
// self-checking bench for the process alarm evaluator
`timescale 1ns/100ps
module paev_top_bench;
  reg ref_clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg psel_i = 1'b0;
  reg penable_i = 1'b0;
  reg pwrite_i = 1'b0;
  reg [11:0] paddr_i = 12'h000;
  reg [31:0] pwdata_i = 32'h0;
  reg heater = 1'b0;
  reg lbreak = 1'b0;
  reg [2:0] rate = 3'h0;
  reg [31:0] xs = 32'h5D;
  reg [31:0] expq [$];
  wire pready;
  wire pslverr;
  wire irq;
  wire [31:0] prdata;
  wire [2:0] aux;
  wire [15:0] pv;
  wire pv_vld;
  integer err_total = 0;
  integer checks = 0;
  integer i;
  integer n;
  int ct [0:16] = '{0, 2, 2, 3, 3, 1, 1, 1, 1, 4, 4, 4, 4, 8, 8, 9, 9};
  int cp [0:16] = '{500, 110, 109, 90, 91, 121, 120, 94, 95, 120, 121, 95, 94, 11, 10, 9, 10};
  int ce [0:16] = '{0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0};
  int st [0:4] = '{5, 6, 7, 10, 11};
  int sa [0:4] = '{130, 130, 70, 130, 0};
  int ss [0:4] = '{100, 100, 100, 5, 50};

  initial forever #4 ref_clk_i = ~ref_clk_i;

  paev_top dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .process_value_i(pv), .process_value_valid_i(pv_vld), .heater_alarm_i(heater),
    .loop_break_alarm_i(lbreak), .rate_alarm_i(rate), .aux_out_o(aux), .irq_o(irq));
  paev_plant plant_u (.ref_clk_i(ref_clk_i), .process_value_o(pv), .process_value_valid_o(pv_vld));

  // ----
  // checking and bus tasks
  // ----
  task check(input [31:0] seen, input [31:0] expv);
    begin
      checks = checks + 1;
      if (seen !== expv) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  function [31:0] xorshift(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xorshift = t ^ (t << 5);
    end
  endfunction
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge ref_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      n = 0;
      @(posedge ref_clk_i);
      while (pready !== 1'b1) begin
        n = n + 1;
        if (n > 50) begin
          err_total = err_total + 1;
          give_verdict;
        end
        @(posedge ref_clk_i);
      end
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input [11:0] a, input [31:0] e);
    begin
      expq.push_back(e);
      apb(1'b0, a, 32'h0);
    end
  endtask
  // fixed settle: pv register, alarm output, aux register
  task wt;
    repeat (4) @(posedge ref_clk_i);
  endtask
  task aux_is(input [2:0] e);
    begin
      wt;
      check({29'h0, aux}, {29'h0, e});
    end
  endtask

  // read data is compared against the oldest note at the sampling edge
  always @(posedge ref_clk_i) begin
    if (psel_i && penable_i && pready === 1'b1 && !pwrite_i && expq.size() > 0)
      check(prdata, expq.pop_front());
  end

  // ----
  // main sequence
  // ----
  initial begin
    repeat (20) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rd(12'h040, 32'h2);
    rd(12'h014, 32'h24);
    rd(12'h010, 32'h0);
    rd(12'h020, 32'h0);
    rd(12'h00C, 32'h7);
    rd(12'h00C, 32'h0);
    wr(12'h010, 32'h1);
    wr(12'h044, 32'hA);
    wt;
    check({31'h0, irq}, 32'h0);
    plant_u.put_pv(16'h0014);
    wt;
    check({31'h0, irq}, 32'h1);
    rd(12'h00C, 32'h1);
    wt;
    check({31'h0, irq}, 32'h0);
    $display("test reset and interrupt done");
    wr(12'h000, 32'h64);
    wr(12'h048, 32'h14);
    wr(12'h04C, 32'h5);
    wr(12'h014, 32'h1);
    for (i = 0; i < 17; i = i + 1) begin
      wr(12'h040, ct[i]);
      plant_u.put_pv(cp[i][15:0]);
      aux_is(ce[i][2:0]);
    end
    $display("test alarm types done");
    for (i = 0; i < 5; i = i + 1) begin
      plant_u.put_pv(sa[i][15:0]);
      wr(12'h040, st[i]);
      wr(12'h008, 32'h1);
      aux_is(3'h0);
      plant_u.put_pv(ss[i][15:0]);
      aux_is(3'h0);
      plant_u.put_pv(sa[i][15:0]);
      aux_is(3'h1);
    end
    $display("test standby done");
    wr(12'h040, 32'hC);
    lbreak <= 1'b1;
    aux_is(3'h1);
    lbreak <= 1'b0;
    aux_is(3'h0);
    wr(12'h040, 32'hD);
    rate <= 3'h1;
    aux_is(3'h1);
    rate <= 3'h0;
    aux_is(3'h0);
    wr(12'h040, 32'h13);
    rd(12'h040, 32'hD);
    wr(12'h060, 32'hC);
    rd(12'h060, 32'h2);
    $display("test special types done");
    wr(12'h040, 32'h8);
    for (i = 0; i < 8; i = i + 1) begin
      xs = xorshift(xs);
      plant_u.put_pv(xs[15:0]);
      aux_is({2'h0, $signed(xs[15:0]) > 16'sh000A});
    end
    plant_u.put_pv(16'h01F4);
    wr(12'h014, 32'h10);
    aux_is(3'h4);
    wr(12'h014, 32'h8);
    aux_is(3'h2);
    wr(12'h014, 32'h0);
    aux_is(3'h0);
    plant_u.put_pv(16'h0000);
    heater <= 1'b1;
    wr(12'h008, 32'h2);
    aux_is(3'h1);
    wr(12'h014, 32'h1);
    aux_is(3'h0);
    heater <= 1'b0;
    wr(12'h008, 32'h0);
    $display("test routing and heater done");
    wr(12'h050, 32'h4D2);
    rd(12'h050, 32'h3E7);
    wr(12'h054, 32'h3E7);
    rd(12'h054, 32'h3E7);
    wr(12'h054, 32'h0);
    plant_u.put_pv(16'h01F4);
    aux_is(3'h0);
    wr(12'h050, 32'h0);
    aux_is(3'h1);
    $display("test delays done");
    give_verdict;
  end
endmodule // paev_top_bench
